// ==== rtl/adr_requests.sv ====
// Purpose: DMA request lines and interrupt flags for a bank of audio serializers.
// Assumes: Serializer events arrive as one-cycle pulses synchronous to clk_i.
// Notes: Flags clear on a read of the flag register or by writing one; a new event wins that cycle.
`timescale 1ns/100ps
module adr_requests
  import adr_pkg::*;
#(
  parameter int N = ADR_NUM_SER
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // AXI4-Lite slave.
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // Serializer side.
  input wire logic [N-1:0] rx_data_ready_i,
  input wire logic [N-1:0] rx_overrun_i,
  input wire logic [N-1:0] tx_empty_i,
  input wire logic [N-1:0] tx_underrun_i,
  input wire logic [N-1:0] slot_odd_i,
  input wire logic [N-1:0] sample_read_i,
  input wire logic [N-1:0] sample_write_i,
  // DMA requests and interrupt.
  output logic [N-1:0] rx_dma_request_line_o,
  output logic [N-1:0] tx_dma_request_line_o,
  output logic irq_o
);
  typedef struct packed {
    logic [N-1:0] per_slot_dma_select;
    logic [N-1:0] is_transmitter;
    logic [N-1:0] compact_stereo;
    adr_src_t [N-1:0] flag;
    adr_src_t [N-1:0] enable;
    logic [N-1:0] rx_pend;
    logic [N-1:0] tx_pend;
    logic [N-1:0] rx_odd;
    logic [N-1:0] tx_odd;
    logic [N-1:0] rx_req;
    logic [N-1:0] tx_req;
    logic irq;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    adr_axi_out_t axi;
  } adr_state_t;

  adr_state_t st;
  adr_state_t next_st;

  logic [31:0] flag_word;
  logic [31:0] en_word;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic do_write;
  logic do_read;

  // Flag and enable words pack each source type into its own byte lane.
  always_comb begin
    flag_word = ADR_RST_WORD;
    en_word = ADR_RST_WORD;
    ctrl_word = ADR_RST_WORD;
    stat_word = ADR_RST_WORD;
    for (int i = 0; i < N; i++) begin
      flag_word[ADR_FLAG_RXRDY_POS + i] = st.flag[i].rx_ready;
      flag_word[ADR_FLAG_RXOR_POS + i] = st.flag[i].rx_overrun;
      flag_word[ADR_FLAG_TXRDY_POS + i] = st.flag[i].tx_ready;
      flag_word[ADR_FLAG_TXUR_POS + i] = st.flag[i].tx_underrun;
      en_word[ADR_FLAG_RXRDY_POS + i] = st.enable[i].rx_ready;
      en_word[ADR_FLAG_RXOR_POS + i] = st.enable[i].rx_overrun;
      en_word[ADR_FLAG_TXRDY_POS + i] = st.enable[i].tx_ready;
      en_word[ADR_FLAG_TXUR_POS + i] = st.enable[i].tx_underrun;
      ctrl_word[ADR_CTRL_SEL_POS + i] = st.per_slot_dma_select[i];
      ctrl_word[ADR_CTRL_TXMODE_POS + i] = st.is_transmitter[i];
      ctrl_word[ADR_CTRL_COMPACT_POS + i] = st.compact_stereo[i];
      stat_word[ADR_FLAG_RXRDY_POS + i] = st.rx_pend[i];
      stat_word[ADR_FLAG_TXRDY_POS + i] = st.tx_pend[i];
    end
  end

  always_comb begin
    wmask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
    wbits = st.w_data & wmask;
    do_write = st.aw_held && st.w_held && !st.axi.bvalid;
    do_read = arvalid_i && !st.axi.rvalid && !st.axi.arready;
  end

  always_comb begin
    next_st = st;
    next_st.axi.awready = 1'b0;
    next_st.axi.wready = 1'b0;
    next_st.axi.arready = 1'b0;
    // Address and data are latched independently, so either may come first.
    if (awvalid_i && !st.aw_held && !st.axi.awready) begin
      next_st.axi.awready = 1'b1;
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr_i;
    end
    if (wvalid_i && !st.w_held && !st.axi.wready) begin
      next_st.axi.wready = 1'b1;
      next_st.w_held = 1'b1;
      next_st.w_data = wdata_i;
      next_st.w_strb = wstrb_i;
    end
    if (st.axi.bvalid && bready_i) begin
      next_st.axi.bvalid = 1'b0;
    end
    if (st.axi.rvalid && rready_i) begin
      next_st.axi.rvalid = 1'b0;
    end

    for (int i = 0; i < N; i++) begin
      // Pending state: set by the serializer, cleared by the data access.
      // A compact stereo word carries both slots of a pair in one transfer, so its
      // single request stays on the serializer's own line whatever the slot parity.
      if (sample_read_i[i]) begin
        next_st.rx_pend[i] = 1'b0; // [RQ10]
      end
      if (rx_data_ready_i[i]) begin
        next_st.rx_pend[i] = 1'b1; // [RQ10]
        next_st.rx_odd[i] = slot_odd_i[i] && !st.compact_stereo[i]; // [RQ5]
      end
      if (sample_write_i[i]) begin
        next_st.tx_pend[i] = 1'b0; // [RQ10]
      end
      if (tx_empty_i[i]) begin
        next_st.tx_pend[i] = 1'b1; // [RQ10]
        next_st.tx_odd[i] = slot_odd_i[i] && !st.compact_stereo[i]; // [RQ5]
      end
      // The lines trail the pending bits by one edge, so a controller must not serve
      // the same line again within two cycles of its access.
      // Request routing; overrun and underrun never reach these lines. [RQ13]
      if (!st.per_slot_dma_select[i]) begin
        next_st.rx_req[i] = !st.is_transmitter[i] && st.rx_pend[i]; // [RQ1] [RQ11]
        next_st.tx_req[i] = st.is_transmitter[i] && st.tx_pend[i]; // [RQ1]
      end else if (!st.is_transmitter[i]) begin
        next_st.rx_req[i] = st.rx_pend[i] && !st.rx_odd[i]; // [RQ2] [RQ11]
        next_st.tx_req[i] = st.rx_pend[i] && st.rx_odd[i]; // [RQ2]
      end else begin
        next_st.tx_req[i] = st.tx_pend[i] && !st.tx_odd[i]; // [RQ2]
        next_st.rx_req[i] = st.tx_pend[i] && st.tx_odd[i]; // [RQ2]
      end
    end

    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.axi.bvalid = 1'b1;
      next_st.axi.bresp = ADR_RESP_OKAY;
      case (st.aw_addr)
        ADR_OFS_CTRL: begin
          for (int i = 0; i < N; i++) begin
            if (wmask[ADR_CTRL_SEL_POS + i]) begin
              next_st.per_slot_dma_select[i] = st.w_data[ADR_CTRL_SEL_POS + i];
            end
            if (wmask[ADR_CTRL_TXMODE_POS + i]) begin
              next_st.is_transmitter[i] = st.w_data[ADR_CTRL_TXMODE_POS + i];
            end
            if (wmask[ADR_CTRL_COMPACT_POS + i]) begin
              next_st.compact_stereo[i] = st.w_data[ADR_CTRL_COMPACT_POS + i]; // [RQ5]
            end
          end
        end
        ADR_OFS_ENSET: begin
          for (int i = 0; i < N; i++) begin
            // Only ones act; zeros leave the enable as it was. [RQ8] [RQ12]
            next_st.enable[i].rx_ready = st.enable[i].rx_ready | wbits[ADR_FLAG_RXRDY_POS + i];
            next_st.enable[i].rx_overrun = st.enable[i].rx_overrun | wbits[ADR_FLAG_RXOR_POS + i];
            next_st.enable[i].tx_ready = st.enable[i].tx_ready | wbits[ADR_FLAG_TXRDY_POS + i];
            next_st.enable[i].tx_underrun = st.enable[i].tx_underrun | wbits[ADR_FLAG_TXUR_POS + i];
          end
        end
        ADR_OFS_ENCLR: begin
          for (int i = 0; i < N; i++) begin
            next_st.enable[i].rx_ready = st.enable[i].rx_ready & ~wbits[ADR_FLAG_RXRDY_POS + i]; // [RQ8]
            next_st.enable[i].rx_overrun = st.enable[i].rx_overrun & ~wbits[ADR_FLAG_RXOR_POS + i];
            next_st.enable[i].tx_ready = st.enable[i].tx_ready & ~wbits[ADR_FLAG_TXRDY_POS + i];
            next_st.enable[i].tx_underrun = st.enable[i].tx_underrun & ~wbits[ADR_FLAG_TXUR_POS + i];
          end
        end
        ADR_OFS_FLAG: begin
          // Writing one clears that flag; an event in the same cycle still sets it below.
          for (int i = 0; i < N; i++) begin
            next_st.flag[i].rx_ready = st.flag[i].rx_ready & ~wbits[ADR_FLAG_RXRDY_POS + i]; // [RQ12]
            next_st.flag[i].rx_overrun = st.flag[i].rx_overrun & ~wbits[ADR_FLAG_RXOR_POS + i];
            next_st.flag[i].tx_ready = st.flag[i].tx_ready & ~wbits[ADR_FLAG_TXRDY_POS + i];
            next_st.flag[i].tx_underrun = st.flag[i].tx_underrun & ~wbits[ADR_FLAG_TXUR_POS + i];
          end
        end
        default: begin
          next_st.axi.bresp = ADR_RESP_SLVERR;
        end
      endcase
    end

    if (do_read) begin
      next_st.axi.arready = 1'b1;
      next_st.axi.rvalid = 1'b1;
      next_st.axi.rresp = ADR_RESP_OKAY;
      case (araddr_i)
        ADR_OFS_CTRL: begin
          next_st.axi.rdata = ctrl_word;
        end
        ADR_OFS_FLAG: begin
          next_st.axi.rdata = flag_word;
          for (int i = 0; i < N; i++) begin
            next_st.flag[i] = '0; // [RQ12]
          end
        end
        ADR_OFS_ENSET, ADR_OFS_ENCLR: begin
          next_st.axi.rdata = en_word; // [RQ12]
        end
        ADR_OFS_STAT: begin
          next_st.axi.rdata = stat_word;
        end
        default: begin
          next_st.axi.rdata = ADR_RST_WORD;
          next_st.axi.rresp = ADR_RESP_SLVERR;
        end
      endcase
    end

    // Events are set after the read and write clears so that a coincident event is kept.
    // Events are taken as clocked pulses; waking from sleep is left to the host, which
    // must keep clk_i running while a source can fire.
    for (int i = 0; i < N; i++) begin
      if (rx_data_ready_i[i]) begin
        next_st.flag[i].rx_ready = 1'b1; // [RQ6] [RQ7]
      end
      if (rx_overrun_i[i]) begin
        next_st.flag[i].rx_overrun = 1'b1; // [RQ6] [RQ7] [RQ13]
      end
      if (tx_empty_i[i]) begin
        next_st.flag[i].tx_ready = 1'b1; // [RQ6] [RQ7]
      end
      if (tx_underrun_i[i]) begin
        next_st.flag[i].tx_underrun = 1'b1; // [RQ6] [RQ7] [RQ13]
      end
    end
    // The request uses the registered flags, so it follows an event by two edges.
    next_st.irq = |(flag_word & en_word); // [RQ9]
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign awready_o = st.axi.awready;
  assign wready_o = st.axi.wready;
  assign bvalid_o = st.axi.bvalid;
  assign bresp_o = st.axi.bresp;
  assign arready_o = st.axi.arready;
  assign rvalid_o = st.axi.rvalid;
  assign rresp_o = st.axi.rresp;
  assign rdata_o = st.axi.rdata;
  assign rx_dma_request_line_o = st.rx_req;
  assign tx_dma_request_line_o = st.tx_req;
  assign irq_o = st.irq;
endmodule : adr_requests

// ==== shared/adr_pkg.sv ====
// Purpose: Constants and types for the serial audio DMA and interrupt request block.
// Assumes: One clock, synchronous active-low reset, AXI4-Lite register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
// Overview of operation
// (RQ1) Per-slot select low: receivers use rx line, transmitters tx line, every slot.
// (RQ2) Per-slot select high: even slots own line, odd slots the opposite line; with compact stereo the code keeps odd slots on own line.
// (RQ3) DMA controller moves every slot through the same sample register, in turn.
// (RQ4) DMA controller sizes transfers to the sample word size setting.
// (RQ5) Compact stereo: 8-bit pairs move in 16 bits, 16-bit pairs in 32.
// (RQ6) Four interrupt sources per serializer: rx ready, overrun, tx ready, underrun.
// (RQ7) Each source owns a flag set whenever its condition occurs.
// (RQ8) Writing one to enable-set enables; one to enable-clear disables.
// (RQ9) Interrupt raised while any flag and its matching enable are set.
// (RQ10) Rx request pends until data read; tx request pends until data written.
// (RQ11) Per-slot select chooses one DMA channel or one channel per slot.
// (RQ12) Zero writes leave enables alone; both read enables; flags clear by read or one.
// (RQ13) Overrun and underrun raise only flags, never a DMA request.
package adr_pkg;
  localparam int ADR_NUM_SER = 2;
  localparam logic [7:0] ADR_OFS_CTRL = 8'h00;
  localparam logic [7:0] ADR_OFS_FLAG = 8'h04;
  localparam logic [7:0] ADR_OFS_ENSET = 8'h08;
  localparam logic [7:0] ADR_OFS_ENCLR = 8'h0C;
  localparam logic [7:0] ADR_OFS_STAT = 8'h10;
  localparam int ADR_CTRL_SEL_POS = 0;
  localparam int ADR_CTRL_TXMODE_POS = 8;
  localparam int ADR_CTRL_COMPACT_POS = 16;
  localparam int ADR_FLAG_RXRDY_POS = 0;
  localparam int ADR_FLAG_RXOR_POS = 8;
  localparam int ADR_FLAG_TXRDY_POS = 16;
  localparam int ADR_FLAG_TXUR_POS = 24;
  localparam logic [31:0] ADR_RST_WORD = 32'h0000_0000;
  localparam logic [1:0] ADR_RESP_OKAY = 2'b00;
  localparam logic [1:0] ADR_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic rx_ready;
    logic rx_overrun;
    logic tx_ready;
    logic tx_underrun;
  } adr_src_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } adr_axi_out_t;
endpackage : adr_pkg

// ==== dv/adr_requests_chk.sv ====
// Purpose: Port checks for adr_requests.
// Assumes: ce_i high; no mode change while a request pends.
// Notes: Bound into every adr_requests.
`timescale 1ns/100ps
module adr_requests_chk #(
  parameter int N = 2
) (
  input wire logic clk_i, rst_b_i, awvalid_i, arvalid_i, bready_i, rready_i,
  input wire logic awready_o, arready_o, bvalid_o, rvalid_o, irq_o,
  input wire logic [N-1:0] rx_data_ready_i, tx_empty_i, sample_read_i, sample_write_i,
  input wire logic [N-1:0] rx_dma_request_line_o, tx_dma_request_line_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_req_on_event: assert property (
    rx_data_ready_i[0] |-> ##2 (rx_dma_request_line_o[0] | tx_dma_request_line_o[0]))
    else $error("request missing after ready event");
  a_req_has_cause: assert property (
    $rose(rx_dma_request_line_o[0] | tx_dma_request_line_o[0]) |-> $past(rx_data_ready_i[0] | tx_empty_i[0], 2))
    else $error("request without ready event");
  a_req_holds: assert property (
    $fell(rx_dma_request_line_o[0] | tx_dma_request_line_o[0]) |-> $past(sample_read_i[0] | sample_write_i[0], 2))
    else $error("request dropped without access");
  a_wr_answer: assert property (awvalid_i && awready_o |-> ##[1:4] bvalid_o)
    else $error("write response late");
  a_bvalid_drop: assert property (bvalid_o && bready_i |=> !bvalid_o)
    else $error("write response repeated");
  a_rd_answer: assert property (arvalid_i && !rvalid_o |=> rvalid_o && arready_o)
    else $error("read answer late");
  a_rvalid_drop: assert property (rvalid_o && rready_i |=> !rvalid_o)
    else $error("read answer repeated");
  a_irq_fall_cause: assert property (
    $fell(irq_o) |-> $past(arvalid_i | awvalid_i, 2) || $past(arvalid_i | awvalid_i, 3))
    else $error("interrupt dropped without access");
endmodule : adr_requests_chk
bind adr_requests adr_requests_chk #(.N(N)) chk_u (.clk_i, .rst_b_i, .awvalid_i, .arvalid_i,
  .bready_i, .rready_i, .awready_o, .arready_o, .bvalid_o, .rvalid_o, .irq_o, .rx_data_ready_i,
  .tx_empty_i, .sample_read_i, .sample_write_i, .rx_dma_request_line_o, .tx_dma_request_line_o);

// ==== dv/adr_dma_model.sv ====
// Purpose: DMA controller model serving the request lines.
// Assumes: is_tx_i mirrors the transmitter bits of the control word.
// Notes: Serves a request DLY+1 cycles after it shows; en_i low stalls and restarts the count.
`timescale 1ns/100ps
module adr_dma_model #(
  parameter int N = 2,
  parameter int DLY = 3
) (
  input wire logic clk_i, rst_b_i, en_i,
  input wire logic [N-1:0] is_tx_i, rx_line_i, tx_line_i,
  output logic [N-1:0] rd_o, wr_o
);
  int cnt[N];
  always @(posedge clk_i) begin
    for (int i = 0; i < N; i++) begin
      rd_o[i] <= 1'b0;
      wr_o[i] <= 1'b0;
      if (!rst_b_i || !en_i || !(rx_line_i[i] | tx_line_i[i])) begin
        cnt[i] <= 0;
      end else if (cnt[i] == DLY) begin
        // Both lines lead to one sample word, slot after slot, sized to the sample.
        rd_o[i] <= !is_tx_i[i];
        wr_o[i] <= is_tx_i[i];
        cnt[i] <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule : adr_dma_model

// ==== dv/serial_audio_dma_irq_requests_tb.sv ====
// Purpose: Self-checking bench for adr_requests.
// Assumes: adr_dma_model plays the controller; ce_i drops only in the freeze check.
// Notes: Registers are reached over AXI4-Lite tasks.
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, a); end end
module serial_audio_dma_irq_requests_tb;
  import adr_pkg::*;
  logic clk_i = 0, rst_b_i = 0, ce_i = 1, en = 0;
  logic awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0, rready_i = 0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
  logic [7:0] awaddr_i = 0, araddr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, rdv;
  logic [3:0] wstrb_i = 4'hf;
  logic [1:0] bresp_o, rresp_o, rsp, erx, etx, is_tx = 0, sample_read_i, sample_write_i;
  logic [1:0] rx_data_ready_i = 0, rx_overrun_i = 0, tx_empty_i = 0, tx_underrun_i = 0, slot_odd_i = 0;
  logic [1:0] rx_dma_request_line_o, tx_dma_request_line_o;
  int failures = 0, checks = 0;
  always #20 clk_i = ~clk_i;
  adr_requests #(.N(2)) dut_u (.clk_i, .rst_b_i, .ce_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i,
    .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
    .rdata_o, .rresp_o, .rvalid_o, .rready_i, .rx_data_ready_i, .rx_overrun_i, .tx_empty_i, .tx_underrun_i,
    .slot_odd_i, .sample_read_i, .sample_write_i, .rx_dma_request_line_o, .tx_dma_request_line_o, .irq_o);
  adr_dma_model dma_u (.clk_i, .rst_b_i, .en_i(en), .is_tx_i(is_tx), .rx_line_i(rx_dma_request_line_o),
    .tx_line_i(tx_dma_request_line_o), .rd_o(sample_read_i), .wr_o(sample_write_i));
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic tmo();
    failures++;
    $display("mismatch wait expected 1 seen 0");
    print_verdict();
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    for (int k = 0; k <= 20; k++) begin
      if (k == 20) tmo();
      @(posedge clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
      if (bvalid_o) break;
    end
    rsp = bresp_o;
    bready_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    for (int k = 0; k <= 20; k++) begin
      if (k == 20) tmo();
      @(posedge clk_i);
      if (arready_o) arvalid_i <= 1'b0;
      if (rvalid_o) break;
    end
    rdv = rdata_o;
    rsp = rresp_o;
    rready_i <= 1'b0;
  endtask : rd
  // Lets the two registered stages behind an event or write land before looking.
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic pulse(input logic [7:0] m, input logic [1:0] odd);
    @(posedge clk_i);
    {tx_underrun_i, tx_empty_i, rx_overrun_i, rx_data_ready_i} <= m;
    slot_odd_i <= odd;
    @(posedge clk_i);
    {tx_underrun_i, tx_empty_i, rx_overrun_i, rx_data_ready_i} <= 8'h00;
    @(posedge clk_i);
    #1;
  endtask : pulse
  task automatic drain();
    en <= 1'b1;
    for (int k = 0; k <= 30; k++) begin
      if (k == 30) tmo();
      @(posedge clk_i);
      if (!(rx_dma_request_line_o | tx_dma_request_line_o)) break;
    end
    en <= 1'b0;
  endtask : drain
  task automatic t_regs();
    rd(ADR_OFS_CTRL);
    `CHK("ctrl reset", ADR_RST_WORD, rdv)
    rd(ADR_OFS_ENSET);
    `CHK("enable reset", ADR_RST_WORD, rdv)
    rd(8'h20);
    `CHK("unmapped read", ADR_RESP_SLVERR, rsp)
    wr(8'h20, 32'hffff_ffff);
    `CHK("unmapped write", ADR_RESP_SLVERR, rsp)
    $display("test regs done");
  endtask : t_regs
  task automatic t_route();
    for (int i = 0; i < 32; i++) begin
      is_tx <= 2'(i[1]) << i[3];
      wr(ADR_OFS_CTRL, (32'(i[2]) << i[3]) | (32'(i[1]) << (ADR_CTRL_TXMODE_POS + i[3]))
        | (32'(i[4]) << (ADR_CTRL_COMPACT_POS + i[3])));
      pulse(8'(8'h05 << i[3]) << (i[1] ? 4 : 0), 2'(i[0]) << i[3]);
      etx = 2'(i[1] ^ (i[2] & i[0] & !i[4])) << i[3];
      erx = 2'(!(i[1] ^ (i[2] & i[0] & !i[4]))) << i[3];
      `CHK("rx line", erx, rx_dma_request_line_o)
      `CHK("tx line", etx, tx_dma_request_line_o)
      `CHK("irq masked", 1'b0, irq_o)
      rd(ADR_OFS_STAT);
      `CHK("pending", 32'h0000_0001 << ((i[1] ? ADR_FLAG_TXRDY_POS : ADR_FLAG_RXRDY_POS) + i[3]), rdv)
      drain();
    end
    $display("test route done");
  endtask : t_route
  task automatic t_irq();
    rd(ADR_OFS_FLAG);
    pulse(8'haa, 2'b00);
    rd(ADR_OFS_FLAG);
    `CHK("flags", 32'h0202_0202, rdv)
    rd(ADR_OFS_FLAG);
    `CHK("flags cleared", ADR_RST_WORD, rdv)
    pulse(8'h08, 2'b00);
    wr(ADR_OFS_ENSET, 32'h0000_0200);
    settle();
    `CHK("irq on", 1'b1, irq_o)
    wr(ADR_OFS_ENSET, 32'h0000_0000);
    rd(ADR_OFS_ENCLR);
    `CHK("enables", 32'h0000_0200, rdv)
    wr(ADR_OFS_ENCLR, 32'h0000_0200);
    settle();
    `CHK("irq off", 1'b0, irq_o)
    wr(ADR_OFS_ENSET, 32'h0000_0200);
    rd(ADR_OFS_FLAG);
    settle();
    `CHK("irq cleared", 1'b0, irq_o)
    pulse(8'h08, 2'b00);
    `CHK("irq again", 1'b1, irq_o)
    wr(ADR_OFS_FLAG, 32'h0000_0200);
    settle();
    `CHK("irq write clear", 1'b0, irq_o)
    @(posedge clk_i);
    ce_i <= 1'b0;
    pulse(8'h08, 2'b00);
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle();
    `CHK("irq frozen", 1'b0, irq_o)
    rd(ADR_OFS_FLAG);
    `CHK("flags frozen", ADR_RST_WORD, rdv)
    $display("test irq done");
  endtask : t_irq
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_route();
    t_irq();
    print_verdict();
  end
endmodule : serial_audio_dma_irq_requests_tb
